// [logic/uad_params.svh]
// Constants for the serial receiver with address detect.
// Included by the package and the receiver; definitions only.
`ifndef UAD_PARAMS_SVH
`define UAD_PARAMS_SVH
// Register indices; the byte address is four times the index
`define UAD_IDX_IRQ_FLAGS  10'h00C
`define UAD_IDX_RX_STATUS  10'h018
`define UAD_IDX_RX_DATA    10'h01A
`define UAD_IDX_IRQ_ENABLE 10'h08C
`define UAD_IDX_TX_STATUS  10'h098
`define UAD_IDX_BAUD       10'h099
// Receive status/control fields
`define UAD_RC_PORT_EN   7
`define UAD_RC_NINE_BIT  6
`define UAD_RC_SINGLE_EN 5
`define UAD_RC_CONT_EN   4
`define UAD_RC_ADDR_DET  3
`define UAD_RC_FRAME_ERR 2
`define UAD_RC_OVERRUN   1
`define UAD_RC_NINTH     0
`define UAD_RC_WMASK     8'hF8
// Transmit status/control fields
`define UAD_TX_CLK_SRC 7
`define UAD_TX_SYNC  4
`define UAD_TX_WMASK 8'hF5
`define UAD_TX_TRMT  8'h02
// Interrupt flag and enable position
`define UAD_IRQ_RC   5
// Reset values
`define UAD_RC_RST   8'h00
`define UAD_TX_RST   8'h02
`define UAD_BAUD_RST 8'h00
// Oversampling: sixteen samples per bit
`define UAD_SMP_MID  4'h7
`define UAD_SMP_LAST 4'hF
`define UAD_BITS_8   4'h7
`define UAD_BITS_9   4'h8
`define UAD_FIFO_FULL 2'h2
// AXI responses
`define UAD_RESP_OKAY   2'h0
`define UAD_RESP_SLVERR 2'h2
`endif

// [logic/uad_pkg.sv]
// Types for the serial receiver with address detect.
// Needs uad_params.svh on the include path.
`include "uad_params.svh"
package uad_pkg;
  typedef enum logic [1:0] {
    UAD_IDLE  = 2'h0,
    UAD_START = 2'h1,
    UAD_DATA  = 2'h3,
    UAD_STOP  = 2'h2
  } uad_rx_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic       ninth;
    logic       frame_err;
  } uad_entry_t;

  typedef struct packed {
    logic [7:0]    rc;
    logic [7:0]    tx;
    logic [7:0]    baud;
    logic          rx_irq_en;
    uad_entry_t    [1:0] fifo;
    logic          head;
    logic [1:0]    count;
    logic          overrun;
    uad_rx_state_t rx_st;
    logic [7:0]    tick_cnt;
    logic [3:0]    smp;
    logic [3:0]    bits;
    logic [8:0]    sr;
    logic          aw_got;
    logic [9:0]    aw_idx;
    logic          w_got;
    logic [7:0]    wdata;
    logic          wstb;
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
    logic          irq;
    logic          sclk_out;
    logic          sclk_oe_n;
  } uad_state_t;
endpackage

// [logic/uad_rx.sv]
// Serial receiver with nine-bit frames, address detect and a two-entry
// receive buffer, behind an AXI4-Lite register slave.
// Assumes rx_in and tx_busy are synchronous to clk; tx_busy comes from
// the companion transmitter.
// Notes on behaviour
// [R1] Nine-bit mode captures nine bits; ninth goes to the ninth-bit flag.
// [R2] Address detect acts only with its enable and nine-bit mode both set.
// [R3] Under address detect a frame is buffered and flagged only if bit 8 is one.
// [R4] The remote master sends ninth bit one for addresses, zero for data.
// [R5] Under address detect a frame with ninth bit zero is not buffered.
// [R6] An ignored data byte is overwritten by the next shifted frame.
// [R7] Address detect enable is ignored in eight-bit mode.
// [R8] Without address detect every frame is buffered, ninth bit passed through.
// [R9] After address detect is cleared, frames buffer whatever their ninth bit.
// [R10] Continuous-receive enable at status bit 4 enables reception.
// [R11] Software clears synchronous select and sets port enable first.
// [R12] Receive-complete flag marks buffered data; interrupt only when enabled.
// [R13] Software reads status before data to keep ninth bit and errors.
// [R14] Clearing continuous-receive enable clears the overrun flag.
// [R15] With address detect, continuous or single receive enable starts reception.
// [R16] Addressed slave software clears address detect to take all bytes.
// [R17] Synchronous master is half duplex; no reception while transmitting.
// [R18] Synchronous mode follows transmit status bit 4.
// [R19] Port enable at status bit 7 hands the pins to the port.
// [R20] Clock-source select at transmit bit 7 makes the port drive the clock.
// [R21] Two-entry buffer; a frame arriving when full sets overrun and is lost.
// [R22] While overrun is set no frame enters the buffer.
// [R23] Framing error set on low stop bit, buffered with its byte.
// [R24] Receive-complete flag is read-only, clears when the buffer is empty.
// [R25] Reading data pops the oldest entry; flags follow the next entry.
`timescale 1ns/1ps
`include "uad_params.svh"
module uad_rx (
  input  wire logic        clk,             // 250 MHz clock
  input  wire logic        sys_rst,         // Sync reset, high
  input  wire logic [11:0] s_axi_awaddr,    // Write address
  input  wire logic        s_axi_awvalid,   // Write address valid
  output logic             s_axi_awready,   // Write address ready
  input  wire logic [31:0] s_axi_wdata,     // Write data
  input  wire logic [3:0]  s_axi_wstrb,     // Byte enables
  input  wire logic        s_axi_wvalid,    // Write data valid
  output logic             s_axi_wready,    // Write data ready
  output logic [1:0]       s_axi_bresp,     // Write response
  output logic             s_axi_bvalid,    // Write response valid
  input  wire logic        s_axi_bready,    // Write response ready
  input  wire logic [11:0] s_axi_araddr,    // Read address
  input  wire logic        s_axi_arvalid,   // Read address valid
  output logic             s_axi_arready,   // Read address ready
  output logic [31:0]      s_axi_rdata,     // Read data
  output logic [1:0]       s_axi_rresp,     // Read response
  output logic             s_axi_rvalid,    // Read data valid
  input  wire logic        s_axi_rready,    // Read data ready
  input  wire logic        rx_in,           // Serial data in
  input  wire logic        tx_busy,         // Transmitter shifting
  output logic             sync_clock_out,  // Shift clock level
  output logic             sync_clock_oe_n, // Clock drive, low drives
  output logic             rx_irq           // Receive interrupt request
);
  uad_pkg::uad_state_t s;
  uad_pkg::uad_state_t next_s;

  always_comb begin
    logic             tick;
    logic             rx_on;
    logic             master;
    logic             addr_mode;
    logic             deliver;
    logic             nb_head;
    logic [1:0]       nb_cnt;
    logic [7:0]       rd;
    logic             hit;
    logic             port_on;
    logic             sync_sel;
    logic             clk_src;
    logic             rx_en_any;
    logic             nine_bit;
    logic             sclk_run;
    uad_pkg::uad_entry_t ent;
    tick      = 1'b0;
    rx_on     = 1'b0;
    master    = 1'b0;
    addr_mode = 1'b0;
    deliver   = 1'b0;
    nb_head   = 1'b0;
    nb_cnt    = 2'h0;
    rd        = 8'h00;
    hit       = 1'b0;
    port_on   = 1'b0;
    sync_sel  = 1'b0;
    clk_src   = 1'b0;
    rx_en_any = 1'b0;
    nine_bit  = 1'b0;
    sclk_run  = 1'b0;
    ent       = '0;
    next_s    = s;

    // Sample tick, sixteen per bit
    tick = (s.tick_cnt == s.baud);
    next_s.tick_cnt = tick ? 8'h00 : s.tick_cnt + 8'h01;

    port_on   = s.rc[`UAD_RC_PORT_EN];                                  // [R19]
    sync_sel  = s.tx[`UAD_TX_SYNC];                                     // [R18]
    clk_src   = s.tx[`UAD_TX_CLK_SRC];                                  // [R20]
    rx_en_any = s.rc[`UAD_RC_CONT_EN] || s.rc[`UAD_RC_SINGLE_EN];       // [R10] [R15]
    nine_bit  = s.rc[`UAD_RC_NINE_BIT];                                 // [R1]
    // Async reception needs port on, async mode and either enable
    rx_on     = port_on && !sync_sel && rx_en_any
                && !tx_busy;                                            // [R17]
    master    = port_on && sync_sel && clk_src;
    addr_mode = nine_bit && s.rc[`UAD_RC_ADDR_DET];                     // [R2] [R7]

    nb_head = s.head;
    nb_cnt  = s.count;

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_got  = 1'b1;
      next_s.aw_idx  = s_axi_awaddr[11:2];
      next_s.awready = 1'b0;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_got  = 1'b1;
      next_s.wdata  = s_axi_wdata[7:0];
      next_s.wstb   = s_axi_wstrb[0];
      next_s.wready = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      hit = 1'b1;
      unique case (s.aw_idx)
        `UAD_IDX_RX_STATUS: begin
          if (s.wstb) begin
            next_s.rc = s.wdata & `UAD_RC_WMASK;
            if (!s.wdata[`UAD_RC_CONT_EN]) begin
              next_s.overrun = 1'b0;                                    // [R14]
            end
          end
        end
        `UAD_IDX_IRQ_ENABLE: begin
          if (s.wstb) begin
            next_s.rx_irq_en = s.wdata[`UAD_IRQ_RC];
          end
        end
        `UAD_IDX_TX_STATUS: begin
          if (s.wstb) begin
            next_s.tx = s.wdata & `UAD_TX_WMASK;
          end
        end
        `UAD_IDX_BAUD: begin
          if (s.wstb) begin
            next_s.baud = s.wdata;
          end
        end
        // Flag and data registers take no writes; flag is hardware owned
        `UAD_IDX_IRQ_FLAGS: hit = 1'b1;                                 // [R24]
        `UAD_IDX_RX_DATA:   hit = 1'b1;
        default:            hit = 1'b0;
      endcase
      next_s.bvalid = 1'b1;
      next_s.bresp  = hit ? `UAD_RESP_OKAY : `UAD_RESP_SLVERR;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid  = 1'b0;
      next_s.aw_got  = 1'b0;
      next_s.w_got   = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready  = 1'b1;
    end

    // Read channel
    if (s_axi_arvalid && s.arready) begin
      hit = 1'b1;
      unique case (s_axi_araddr[11:2])
        `UAD_IDX_IRQ_FLAGS: begin
          rd = 8'h00;
          rd[`UAD_IRQ_RC] = (s.count != 2'h0);                         // [R12] [R24]
        end
        `UAD_IDX_RX_STATUS: begin
          // Control bits echo; frame-error and ninth-bit flags show the oldest buffered frame
          rd[`UAD_RC_PORT_EN]   = s.rc[`UAD_RC_PORT_EN];
          rd[`UAD_RC_NINE_BIT]  = s.rc[`UAD_RC_NINE_BIT];
          rd[`UAD_RC_SINGLE_EN] = s.rc[`UAD_RC_SINGLE_EN];
          rd[`UAD_RC_CONT_EN]   = s.rc[`UAD_RC_CONT_EN];
          rd[`UAD_RC_ADDR_DET]  = s.rc[`UAD_RC_ADDR_DET];
          rd[`UAD_RC_FRAME_ERR] = s.fifo[s.head].frame_err;             // [R23]
          rd[`UAD_RC_OVERRUN]   = s.overrun;
          rd[`UAD_RC_NINTH]     = s.fifo[s.head].ninth;                 // [R1]
        end
        `UAD_IDX_RX_DATA: begin
          rd = s.fifo[s.head].data;
          if (s.count != 2'h0) begin
            nb_head = ~s.head;                                          // [R25]
            nb_cnt  = s.count - 2'h1;
          end
        end
        `UAD_IDX_IRQ_ENABLE: begin
          rd = 8'h00;
          rd[`UAD_IRQ_RC] = s.rx_irq_en;
        end
        `UAD_IDX_TX_STATUS: rd = s.tx | `UAD_TX_TRMT;
        `UAD_IDX_BAUD:      rd = s.baud;
        default: begin
          rd  = 8'h00;
          hit = 1'b0;
        end
      endcase
      next_s.arready = 1'b0;
      next_s.rvalid  = 1'b1;
      next_s.rdata   = {24'h000000, rd};
      next_s.rresp   = hit ? `UAD_RESP_OKAY : `UAD_RESP_SLVERR;
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid  = 1'b0;
      next_s.arready = 1'b1;
    end

    // Receive sequencer
    if (!rx_on) begin
      next_s.rx_st = uad_pkg::UAD_IDLE;
    end else if (tick) begin
      unique case (s.rx_st)
        uad_pkg::UAD_IDLE: begin
          if (!rx_in) begin
            next_s.rx_st = uad_pkg::UAD_START;
            next_s.smp   = 4'h0;
          end
        end
        uad_pkg::UAD_START: begin
          // Recheck at mid bit to reject glitches
          if (s.smp == `UAD_SMP_MID) begin
            next_s.smp  = 4'h0;
            next_s.bits = 4'h0;
            next_s.rx_st = rx_in ? uad_pkg::UAD_IDLE : uad_pkg::UAD_DATA;
          end else begin
            next_s.smp = s.smp + 4'h1;
          end
        end
        uad_pkg::UAD_DATA: begin
          next_s.smp = s.smp + 4'h1;
          if (s.smp == `UAD_SMP_LAST) begin
            // New frame overwrites any ignored byte
            next_s.sr   = {rx_in, s.sr[8:1]};                           // [R6]
            next_s.bits = s.bits + 4'h1;
            if (s.bits == (nine_bit ? `UAD_BITS_9 : `UAD_BITS_8)) begin
              next_s.rx_st = uad_pkg::UAD_STOP;                         // [R1]
            end
          end
        end
        uad_pkg::UAD_STOP: begin
          next_s.smp = s.smp + 4'h1;
          if (s.smp == `UAD_SMP_LAST) begin
            next_s.rx_st = uad_pkg::UAD_IDLE;
            if (nine_bit) begin
              ent.data  = s.sr[7:0];
              ent.ninth = s.sr[8];                                      // [R1] [R8]
            end else begin
              ent.data  = s.sr[8:1];
              ent.ninth = 1'b0;
            end
            ent.frame_err = !rx_in;                                     // [R23]
            deliver = !addr_mode || s.sr[8];                            // [R3] [R5] [R9]
            // A pop in this cycle has already freed its slot
            if (deliver && !s.overrun) begin                            // [R22]
              if (nb_cnt == `UAD_FIFO_FULL) begin
                next_s.overrun = 1'b1;                                  // [R21]
              end else begin
                next_s.fifo[nb_head ^ nb_cnt[0]] = ent;                 // [R21]
                nb_cnt = nb_cnt + 2'h1;
              end
            end
          end
        end
      endcase
    end
    next_s.head  = nb_head;
    next_s.count = nb_cnt;

    // Interrupt request follows buffered data and its enable
    next_s.irq = (nb_cnt != 2'h0) && next_s.rx_irq_en;                  // [R12]

    // Synchronous master owns the clock line; idles high
    // Parked while transmitting so no receive edges are made
    sclk_run = master && rx_en_any && !tx_busy;                         // [R17]
    next_s.sclk_oe_n = !master;                                         // [R19] [R20]
    if (sclk_run) begin
      if (tick) begin
        next_s.sclk_out = ~s.sclk_out;                                  // [R20]
      end
    end else begin
      next_s.sclk_out = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // Every field named, so none is left to chance
      s.rc        <= `UAD_RC_RST;
      s.tx        <= `UAD_TX_RST & `UAD_TX_WMASK;
      s.baud      <= `UAD_BAUD_RST;
      s.rx_irq_en <= 1'b0;

      s.fifo      <= '0;
      s.head      <= 1'b0;
      s.count     <= 2'h0;
      s.overrun   <= 1'b0;

      s.rx_st     <= uad_pkg::UAD_IDLE;
      s.tick_cnt  <= 8'h00;
      s.smp       <= 4'h0;
      s.bits      <= 4'h0;
      s.sr        <= 9'h000;

      s.aw_got    <= 1'b0;
      s.aw_idx    <= 10'h000;
      s.w_got     <= 1'b0;
      s.wdata     <= 8'h00;
      s.wstb      <= 1'b0;
      s.awready   <= 1'b1;
      s.wready    <= 1'b1;
      s.bvalid    <= 1'b0;
      s.bresp     <= `UAD_RESP_OKAY;
      s.arready   <= 1'b1;
      s.rvalid    <= 1'b0;
      s.rdata     <= 32'h00000000;
      s.rresp     <= `UAD_RESP_OKAY;

      s.irq       <= 1'b0;
      s.sclk_out  <= 1'b1;
      s.sclk_oe_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready   = s.awready;
  assign s_axi_wready    = s.wready;
  assign s_axi_bresp     = s.bresp;
  assign s_axi_bvalid    = s.bvalid;
  assign s_axi_arready   = s.arready;
  assign s_axi_rdata     = s.rdata;
  assign s_axi_rresp     = s.rresp;
  assign s_axi_rvalid    = s.rvalid;
  assign sync_clock_out  = s.sclk_out;
  assign sync_clock_oe_n = s.sclk_oe_n;
  assign rx_irq          = s.irq;
endmodule

// [bench/uad_properties.sv]
// Concurrent checks on the receiver's bus, interrupt and clock ports.
// Bound into every uad_rx; one clock domain, reset sys_rst.
`timescale 1ns/1ps
module uad_properties (
  input wire logic        clk,             // Clock
  input wire logic        sys_rst,         // Reset
  input wire logic        s_axi_awvalid,   // AW valid
  input wire logic        s_axi_awready,   // AW ready
  input wire logic        s_axi_wvalid,    // W valid
  input wire logic        s_axi_wready,    // W ready
  input wire logic [1:0]  s_axi_bresp,     // B resp
  input wire logic        s_axi_bvalid,    // B valid
  input wire logic        s_axi_bready,    // B ready
  input wire logic        s_axi_arvalid,   // AR valid
  input wire logic        s_axi_arready,   // AR ready
  input wire logic [31:0] s_axi_rdata,     // R data
  input wire logic [1:0]  s_axi_rresp,     // R resp
  input wire logic        s_axi_rvalid,    // R valid
  input wire logic        s_axi_rready,    // R ready
  input wire logic        tx_busy,         // Transmitter busy
  input wire logic        sync_clock_out,  // Shift clock
  input wire logic        sync_clock_oe_n, // Clock drive
  input wire logic        rx_irq           // Interrupt
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_AW_HOLD: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address ready stayed high after take");
  AST_B_TIME: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  AST_R_NEXT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  AST_R_NARROW: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0
    && (s_axi_rresp == 2'h0 || s_axi_rresp == 2'h2))
    else $error("read word malformed");
  AST_IRQ_FALL: assert property (
    $fell(rx_irq) |-> $past(s_axi_arvalid) || $past(s_axi_arvalid, 2)
      || $past(s_axi_wvalid) || $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3))
    else $error("interrupt dropped without a bus access");
  AST_HALF_DUPLEX: assert property (tx_busy ##1 tx_busy |-> sync_clock_out)
    else $error("shift clock ran while transmitting");
  AST_CLK_PARK: assert property (sync_clock_oe_n [*2] |-> sync_clock_out)
    else $error("shift clock low while not driven");
  AST_RST_IDLE: assert property ($fell(sys_rst) |-> !rx_irq && !s_axi_bvalid && sync_clock_oe_n)
    else $error("outputs not idle after reset");
endmodule

bind uad_rx uad_properties uad_properties_inst (.clk, .sys_rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_busy,
  .sync_clock_out, .sync_clock_oe_n, .rx_irq);

// [bench/uad_serial_src.sv]
// Remote serial transmitter driving the receive line.
// Idle high; bit period is BIT_CYC clk cycles; calls start after an edge.
`timescale 1ns/1ps
module uad_serial_src #(
  parameter int BIT_CYC = 16
) (
  input  wire logic clk,  // Bench clock
  output logic      line  // Serial line
);
  initial line = 1'b1;
  task automatic hold(input logic v, input int n);
    line <= v;
    repeat (n) @(posedge clk);
  endtask
  // Ninth bit one marks an address, zero a data byte
  task automatic send(input logic [8:0] d, input int nb, input logic stop);
    hold(1'b0, BIT_CYC);
    for (int b = 0; b < nb; b++) hold(d[b], BIT_CYC);
    // Short stop so a low stop cannot pass for a new start
    hold(stop, BIT_CYC * 3 / 4);
    hold(1'b1, 2 * BIT_CYC);
  endtask
endmodule

// [bench/tb_top.sv]
// Self-checking bench: AXI4-Lite tasks, serial frames, port checks.
// Baud divisor 0 gives 16 clk cycles per bit on the serial line.
`timescale 1ns/1ps
`include "uad_params.svh"
module tb_top;
  localparam logic [11:0] A_FLG = {`UAD_IDX_IRQ_FLAGS, 2'h0};
  localparam logic [11:0] A_ST  = {`UAD_IDX_RX_STATUS, 2'h0};
  localparam logic [11:0] A_DAT = {`UAD_IDX_RX_DATA, 2'h0};
  localparam logic [11:0] A_IE  = {`UAD_IDX_IRQ_ENABLE, 2'h0};
  localparam logic [11:0] A_TX  = {`UAD_IDX_TX_STATUS, 2'h0};
  localparam logic [11:0] A_BD  = {`UAD_IDX_BAUD, 2'h0};
  logic        clk, sys_rst, rx_in, tx_busy, rx_irq, sync_clock_out, sync_clock_oe_n;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] ra [6];
  logic [7:0]  rv [6];
  int          n_errors, n_compared, i;

  uad_rx uad_rx_inst (.*);
  uad_serial_src #(.BIT_CYC(16)) src (.clk(clk), .line(rx_in));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic summarize;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic tick(inout int k);
    @(posedge clk);
    k++;
    if (k > 300) begin
      n_errors++;
      summarize();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic [1:0] er = 2'h0);
    int k;
    k = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      tick(k);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    while (!s_axi_bvalid) tick(k);
    s_axi_bready <= 1'b1;
    tick(k);
    chk(s_axi_bresp, er);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] v, input logic [1:0] er = 2'h0);
    int k;
    k = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do tick(k); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) tick(k);
    s_axi_rready <= 1'b1;
    tick(k);
    chk(s_axi_rdata, {24'h0, v});
    chk(s_axi_rresp, er);
    s_axi_rready <= 1'b0;
  endtask

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, tx_busy} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    ra = '{A_FLG, A_ST, A_DAT, A_IE, A_TX, A_BD};
    rv = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
    sys_rst = 1'b1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    for (int j = 0; j < 6; j++) rd(ra[j], rv[j]);
    rd(12'h004, 8'h00, 2'h2);
    wr(12'h004, 8'hFF, 2'h2);
    wr(A_TX, 8'hFF);
    rd(A_TX, 8'hF7);
    s_axi_wstrb <= 4'hE;
    wr(A_BD, 8'h33);
    s_axi_wstrb <= 4'hF;
    rd(A_BD, 8'h00);
    wr(A_TX, 8'h00);
    wr(A_BD, 8'h00);
    wr(A_IE, 8'h20);
    wr(A_ST, 8'hE8);
    src.send(9'h055, 9, 1'b1);
    rd(A_FLG, 8'h00);
    chk(rx_irq, 1'b0);
    src.send(9'h1A3, 9, 1'b1);
    rd(A_FLG, 8'h20);
    chk(rx_irq, 1'b1);
    rd(A_ST, 8'hE9);
    rd(A_DAT, 8'hA3);
    rd(A_FLG, 8'h00);
    wr(A_ST, 8'hD0);
    src.send(9'h03C, 9, 1'b1);
    rd(A_ST, 8'hD0);
    rd(A_DAT, 8'h3C);
    wr(A_ST, 8'h98);
    src.send(9'h05A, 8, 1'b1);
    rd(A_DAT, 8'h5A);
    wr(A_ST, 8'hD0);
    src.send(9'h101, 9, 1'b0);
    src.send(9'h002, 9, 1'b1);
    src.send(9'h103, 9, 1'b1);
    rd(A_ST, 8'hD7);
    chk(rx_irq, 1'b1);
    wr(A_IE, 8'h00);
    chk(rx_irq, 1'b0);
    rd(A_DAT, 8'h01);
    rd(A_ST, 8'hD2);
    rd(A_DAT, 8'h02);
    src.send(9'h044, 9, 1'b1);
    rd(A_FLG, 8'h00);
    wr(A_ST, 8'hC0);
    wr(A_ST, 8'hD0);
    src.send(9'h0EE, 9, 1'b1);
    rd(A_ST, 8'hD0);
    rd(A_DAT, 8'hEE);
    wr(A_TX, 8'h90);
    wr(A_ST, 8'h90);
    tx_busy <= 1'b1;
    repeat (20) @(posedge clk);
    chk(sync_clock_oe_n, 1'b0);
    chk(sync_clock_out, 1'b1);
    tx_busy <= 1'b0;
    i = 0;
    while (sync_clock_out) tick(i);
    wr(A_TX, 8'h10);
    repeat (4) @(posedge clk);
    chk(sync_clock_oe_n, 1'b1);
    summarize();
  end
endmodule
